// ==== core/lai_irq_unit.sv ====
// Purpose: Interrupt enable and status logic of a video link serializer
// Assumes: Event inputs are one-cycle pulses from logic on ref_clk
// Notes:   Reading the status register clears the source flags
//          Flags record every event; enables gate only bit 0 and the line
//          A status write is ignored; unmapped reads return zero
//          Flag and interrupt line rise together at the same edge
//
// Summary of operation
// - Bit 7 flags indirect access done, recorded even when disabled
// - Bit 6 flags receiver detected, recorded even when disabled
// - Bit 5 flags downstream interrupt, recorded even when disabled
// - Bit 4 flags key list ready, recorded even when disabled
// - Bit 3 flags receiver key vector ready, recorded even when disabled
// - Bit 2 flags authentication failure or loss, recorded even when disabled
// - Bit 1 flags authentication success, recorded even when disabled
// - Interrupt line driven only with global enable
// - Status bit 0 set when enabled source pending
`timescale 1ns/100ps

module lai_irq_unit #(
  // Register port geometry; the register map is fixed to these values
  parameter int ADDR_W = lai_pkg::REG_AW,
  parameter int DATA_W = lai_pkg::REG_DW,
  // Event sources in the status register, one per bit above bit 0
  parameter int SRC_N  = lai_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  input  wire logic [DATA_W-1:0]    regWrData,
  output logic      [DATA_W-1:0]    regRdData,
  // Event pulses
  input  wire logic                 evIndirectDone,
  input  wire logic                 evReceiverDetect,
  input  wire logic                 evDownstreamIrq,
  input  wire logic                 evKeylistReady,
  input  wire logic                 evKeyvectorReady,
  input  wire logic                 evAuthFailure,
  input  wire logic                 evAuthSuccess,
  // Interrupt to controller, active high
  output logic                      irqOut
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // Each flag owns one bit of a one-byte register, so the geometry cannot
  // be stretched without a new register map
  if (ADDR_W != 8) begin : g_chk_addr_w
    $error("lai_irq_unit needs ADDR_W of 8");
  end
  if (DATA_W != 8) begin : g_chk_data_w
    $error("lai_irq_unit needs DATA_W of 8");
  end
  if (SRC_N != 7) begin : g_chk_src_n
    $error("lai_irq_unit needs SRC_N of 7");
  end
  // The flag packing below assumes this bit order
  if (lai_pkg::BIT_GLOBAL != 0) begin : g_chk_bit0
    $error("lai_irq_unit global bit must be 0");
  end
  if (lai_pkg::BIT_AUTH_OK != 1) begin : g_chk_bit1
    $error("lai_irq_unit success bit must be 1");
  end
  if (lai_pkg::BIT_AUTH_FAIL != 2) begin : g_chk_bit2
    $error("lai_irq_unit failure bit must be 2");
  end
  if (lai_pkg::BIT_KEYVEC != 3) begin : g_chk_bit3
    $error("lai_irq_unit key vector bit must be 3");
  end
  if (lai_pkg::BIT_KEYLIST != 4) begin : g_chk_bit4
    $error("lai_irq_unit key list bit must be 4");
  end
  if (lai_pkg::BIT_DOWNSTRM != 5) begin : g_chk_bit5
    $error("lai_irq_unit downstream bit must be 5");
  end
  if (lai_pkg::BIT_RXDET != 6) begin : g_chk_bit6
    $error("lai_irq_unit receiver detect bit must be 6");
  end
  if (lai_pkg::BIT_INDIRECT != 7) begin : g_chk_bit7
    $error("lai_irq_unit indirect access bit must be 7");
  end
  // Both registers must decode apart
  if (lai_pkg::ADDR_IRQ_EN == lai_pkg::ADDR_IRQ_ST) begin : g_chk_addr
    $error("lai_irq_unit register offsets collide");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helper functions
  // Register decode, shared by the write path and the clear-on-read path
  function automatic logic addrIs(input logic [ADDR_W-1:0] addr, input logic [7:0] target);
    addrIs = (addr == target);
  endfunction : addrIs

  // Sticky flag: an event in the clearing read cycle wins, so none is lost
  function automatic logic flagNext(input logic cur, input logic ev, input logic clr);
    flagNext = (cur && !clr) || ev;
  endfunction : flagNext

  ////////////////////////////////////////////////////////////////////////
  // Internal state
  logic [7:0] enable_reg;
  logic       stIndirectDone_reg;
  logic       stReceiverDetect_reg;
  logic       stDownstreamIrq_reg;
  logic       stKeylistReady_reg;
  logic       stKeyvectorReady_reg;
  logic       stAuthFailure_reg;
  logic       stAuthSuccess_reg;
  // Decode and combinational views
  logic       wrEnable;
  logic       rdStatus;
  logic       enGlobal;
  logic       enIndirectDone;
  logic       enReceiverDetect;
  logic       enDownstreamIrq;
  logic       enKeylistReady;
  logic       enKeyvectorReady;
  logic       enAuthFailure;
  logic       enAuthSuccess;
  logic [7:1] flagsNow;
  logic [7:1] flagsNext;
  logic [7:1] pendingNow;
  logic [7:1] pendingNext;
  logic       anyPending;
  logic       irqNext;
  logic [7:0] rdMux;

  ////////////////////////////////////////////////////////////////////////
  // Register decode
  assign wrEnable = regWrEn && addrIs(regAddr, lai_pkg::ADDR_IRQ_EN);
  // Writes aimed at the status address match nothing here and are dropped
  assign rdStatus = regRdEn && addrIs(regAddr, lai_pkg::ADDR_IRQ_ST);

  ////////////////////////////////////////////////////////////////////////
  // Enable register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= lai_pkg::RST_IRQ_EN;
    end else if (wrEnable) begin
      enable_reg <= regWrData;
    end
  end

  assign enGlobal         = enable_reg[lai_pkg::BIT_GLOBAL];
  assign enIndirectDone   = enable_reg[lai_pkg::BIT_INDIRECT];
  assign enReceiverDetect = enable_reg[lai_pkg::BIT_RXDET];
  assign enDownstreamIrq  = enable_reg[lai_pkg::BIT_DOWNSTRM];
  assign enKeylistReady   = enable_reg[lai_pkg::BIT_KEYLIST];
  assign enKeyvectorReady = enable_reg[lai_pkg::BIT_KEYVEC];
  assign enAuthFailure    = enable_reg[lai_pkg::BIT_AUTH_FAIL];
  assign enAuthSuccess    = enable_reg[lai_pkg::BIT_AUTH_OK];

  ////////////////////////////////////////////////////////////////////////
  // Next flag values; flags record events whether enabled or not, and the
  // enables gate only the summary bit and the interrupt line
  assign flagsNext[lai_pkg::BIT_INDIRECT]  = flagNext(stIndirectDone_reg,   evIndirectDone,   rdStatus);
  assign flagsNext[lai_pkg::BIT_RXDET]     = flagNext(stReceiverDetect_reg, evReceiverDetect, rdStatus);
  assign flagsNext[lai_pkg::BIT_DOWNSTRM]  = flagNext(stDownstreamIrq_reg,  evDownstreamIrq,  rdStatus);
  assign flagsNext[lai_pkg::BIT_KEYLIST]   = flagNext(stKeylistReady_reg,   evKeylistReady,   rdStatus);
  assign flagsNext[lai_pkg::BIT_KEYVEC]    = flagNext(stKeyvectorReady_reg, evKeyvectorReady, rdStatus);
  assign flagsNext[lai_pkg::BIT_AUTH_FAIL] = flagNext(stAuthFailure_reg,    evAuthFailure,    rdStatus);
  assign flagsNext[lai_pkg::BIT_AUTH_OK]   = flagNext(stAuthSuccess_reg,    evAuthSuccess,    rdStatus);

  ////////////////////////////////////////////////////////////////////////
  // Source flags, one register per source

  // Indirect register access finished
  // Held until the host reads status
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stIndirectDone_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_INDIRECT];
    end else begin
      stIndirectDone_reg <= flagsNext[lai_pkg::BIT_INDIRECT];
    end
  end

  // Downstream receiver detected
  // A repeat detection before the read is merged
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stReceiverDetect_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_RXDET];
    end else begin
      stReceiverDetect_reg <= flagsNext[lai_pkg::BIT_RXDET];
    end
  end

  // Receiver passed on a downstream request
  // Several requests before a read count as one
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stDownstreamIrq_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_DOWNSTRM];
    end else begin
      stDownstreamIrq_reg <= flagsNext[lai_pkg::BIT_DOWNSTRM];
    end
  end

  // Key-vector list ready for the host
  // Stays set while the host fetches the list
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stKeylistReady_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_KEYLIST];
    end else begin
      stKeylistReady_reg <= flagsNext[lai_pkg::BIT_KEYLIST];
    end
  end

  // Receiver key vector ready for the host
  // Stays set until the status read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stKeyvectorReady_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_KEYVEC];
    end else begin
      stKeyvectorReady_reg <= flagsNext[lai_pkg::BIT_KEYVEC];
    end
  end

  // Authentication failed or was lost later
  // One flag covers both cases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stAuthFailure_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_AUTH_FAIL];
    end else begin
      stAuthFailure_reg <= flagsNext[lai_pkg::BIT_AUTH_FAIL];
    end
  end

  // Authentication completed successfully
  // Independent of the failure flag
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stAuthSuccess_reg <= lai_pkg::RST_IRQ_ST[lai_pkg::BIT_AUTH_OK];
    end else begin
      stAuthSuccess_reg <= flagsNext[lai_pkg::BIT_AUTH_OK];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Summary
  assign flagsNow = {stIndirectDone_reg, stReceiverDetect_reg, stDownstreamIrq_reg, stKeylistReady_reg,
                     stKeyvectorReady_reg, stAuthFailure_reg, stAuthSuccess_reg};

  assign pendingNow[lai_pkg::BIT_INDIRECT]  = stIndirectDone_reg   && enIndirectDone;
  assign pendingNow[lai_pkg::BIT_RXDET]     = stReceiverDetect_reg && enReceiverDetect;
  assign pendingNow[lai_pkg::BIT_DOWNSTRM]  = stDownstreamIrq_reg  && enDownstreamIrq;
  assign pendingNow[lai_pkg::BIT_KEYLIST]   = stKeylistReady_reg   && enKeylistReady;
  assign pendingNow[lai_pkg::BIT_KEYVEC]    = stKeyvectorReady_reg && enKeyvectorReady;
  assign pendingNow[lai_pkg::BIT_AUTH_FAIL] = stAuthFailure_reg    && enAuthFailure;
  assign pendingNow[lai_pkg::BIT_AUTH_OK]   = stAuthSuccess_reg    && enAuthSuccess;
  // Combinational so that a status read sees an enable change at once
  assign anyPending = |pendingNow;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt line
  // Built from the next flags so the line rises at the edge that sets the
  // flag; the global enable gates the line but not status bit 0
  assign pendingNext[lai_pkg::BIT_INDIRECT]  = flagsNext[lai_pkg::BIT_INDIRECT]  && enIndirectDone;
  assign pendingNext[lai_pkg::BIT_RXDET]     = flagsNext[lai_pkg::BIT_RXDET]     && enReceiverDetect;
  assign pendingNext[lai_pkg::BIT_DOWNSTRM]  = flagsNext[lai_pkg::BIT_DOWNSTRM]  && enDownstreamIrq;
  assign pendingNext[lai_pkg::BIT_KEYLIST]   = flagsNext[lai_pkg::BIT_KEYLIST]   && enKeylistReady;
  assign pendingNext[lai_pkg::BIT_KEYVEC]    = flagsNext[lai_pkg::BIT_KEYVEC]    && enKeyvectorReady;
  assign pendingNext[lai_pkg::BIT_AUTH_FAIL] = flagsNext[lai_pkg::BIT_AUTH_FAIL] && enAuthFailure;
  assign pendingNext[lai_pkg::BIT_AUTH_OK]   = flagsNext[lai_pkg::BIT_AUTH_OK]   && enAuthSuccess;

  always_comb begin
    irqNext = enGlobal && (|pendingNext);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqOut <= 1'h0;
    end else begin
      irqOut <= irqNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path; unmapped reads return zero
  always_comb begin
    rdMux = 8'h00;
    case (regAddr)
      lai_pkg::ADDR_IRQ_EN: rdMux = enable_reg;
      lai_pkg::ADDR_IRQ_ST: rdMux = {flagsNow, anyPending};
      default:              rdMux = 8'h00;
    endcase
  end

  // Read data stands until the next read strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

endmodule : lai_irq_unit

// ==== dv/lai_host_model.sv ====
// Purpose: Host sampling the interrupt line. Assumes: level interrupt. Notes: sticky so short pulses are not missed
`timescale 1ns/100ps
module lai_host_model (input wire logic ref_clk, arst_n, irqOut, output logic irqSeen);
  always_ff @(posedge ref_clk or negedge arst_n) irqSeen <= !arst_n ? 1'h0 : irqSeen | irqOut;
endmodule : lai_host_model

// ==== dv/lai_irq_unit_asserts.sv ====
// Purpose: Port checks for lai_irq_unit. Assumes: single ref_clk domain. Notes: enable mirror kept locally
`timescale 1ns/100ps
module lai_irq_asserts (input wire logic ref_clk, arst_n, regWrEn, regRdEn, irqOut, evIndirectDone, evReceiverDetect,
  evDownstreamIrq, evKeylistReady, evKeyvectorReady, evAuthFailure, evAuthSuccess,
  input wire logic [7:0] regAddr, regWrData, regRdData);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic [7:1] ev = {evIndirectDone, evReceiverDetect, evDownstreamIrq, evKeylistReady, evKeyvectorReady,
    evAuthFailure, evAuthSuccess};
  wire logic rs = regRdEn && regAddr == 8'hC7;
  logic [7:0] enR;
  always_ff @(posedge ref_clk or negedge arst_n)
    enR <= !arst_n ? 8'h00 : (regWrEn && regAddr == 8'hC6) ? regWrData : enR;
  property p_set; ev != 7'h00 ##1 rs |=> (regRdData[7:1] & $past(ev, 2)) == $past(ev, 2); endproperty
  a_set: assert property (p_set) else $error("flag lost");
  property p_clr; rs && ev == 7'h00 ##1 ev == 7'h00 ##1 rs |=> regRdData[7:1] == 7'h00; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_glb; rs |=> regRdData[0] == |(regRdData[7:1] & $past(enR[7:1])); endproperty
  a_glb: assert property (p_glb) else $error("global");
  property p_on; evAuthSuccess && enR[1] && enR[0] && !regWrEn |=> irqOut; endproperty
  a_on: assert property (p_on) else $error("irq late");
  property p_off; irqOut |-> enR[0] || $past(enR[0]); endproperty
  a_off: assert property (p_off) else $error("irq ungated");
  property p_rw; regWrEn && regAddr == 8'hC6 ##2 regRdEn && regAddr == 8'hC6 |=> regRdData == $past(regWrData, 3);
  endproperty
  a_rw: assert property (p_rw) else $error("enable rw");
  property p_unm; regRdEn && regAddr[7:1] != 7'h63 |=> regRdData == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_hold; !regRdEn |=> $stable(regRdData); endproperty
  a_hold: assert property (p_hold) else $error("rd hold");
  c_irq: cover property (irqOut);
  c_set: cover property (ev != 7'h00 ##1 rs);
  c_glb: cover property (rs ##1 regRdData[0]);
endmodule : lai_irq_asserts
bind lai_irq_unit lai_irq_asserts u_chk (.*);

// ==== dv/tb_lai_irq_unit.sv ====
// Purpose: Bench for lai_irq_unit. Assumes: inputs change on falling edge. Notes: random events, seed 95
`timescale 1ns/100ps
module tb_lai_irq_unit;
  logic       ref_clk = 0, arst_n = 0, regWrEn = 0, regRdEn = 0, irqOut, irqSeen;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, e, p, r;
  logic [7:1] ev = 7'h00;
  int         bad_count = 0, cmp_count = 0;
  always #2 ref_clk = ~ref_clk;
  lai_irq_unit u_dut (.ref_clk, .arst_n, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData, .irqOut,
    .evIndirectDone(ev[7]), .evReceiverDetect(ev[6]), .evDownstreamIrq(ev[5]), .evKeylistReady(ev[4]),
    .evKeyvectorReady(ev[3]), .evAuthFailure(ev[2]), .evAuthSuccess(ev[1]));
  lai_host_model u_host (.ref_clk, .arst_n, .irqOut, .irqSeen);
  task automatic chk(input string n, input logic [7:0] s, x); cmp_count++;
    if (s !== x) begin bad_count++; $display("CHECK FAILED %s exp %h seen %h", n, x, s); end endtask : chk
  // Expected status word and interrupt level from flags and enables
  function automatic logic [7:0] exp_st(input logic [7:1] f, input logic [7:0] en); return {f, |(f & en[7:1])};
  endfunction : exp_st
  function automatic logic exp_irq(input logic [7:1] f, input logic [7:0] en); return |(f & en[7:1]) && en[0];
  endfunction : exp_irq
  // Strobe is a single cycle, then one idle cycle so read data has settled
  task automatic acc(input logic w, input logic [7:0] a, d); regAddr = a; regWrData = d; regWrEn = w; regRdEn = !w;
    @(negedge ref_clk); regWrEn = 0; regRdEn = 0; @(negedge ref_clk); r = regRdData; endtask : acc
  task automatic end_of_test; $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS"); else $display("TB: FAIL"); $finish; endtask : end_of_test
  initial begin #100000; bad_count++; end_of_test(); end
  initial begin
    e = $urandom(95);
    repeat (20) @(negedge ref_clk); arst_n = 1;
    acc(0, 8'hC6, 8'h00); chk("en reset", r, 8'h00);
    acc(0, 8'hC7, 8'h00); chk("st reset", r, 8'h00);
    acc(0, 8'h5A, 8'h00); chk("unmapped", r, 8'h00);
    repeat (40) begin
      e = $urandom; p = $urandom;
      acc(1, 8'hC6, e); acc(0, 8'hC6, 8'h00); chk("en", r, e);
      acc(1, 8'hC7, 8'hFF); ev = p[7:1]; @(negedge ref_clk); ev = 7'h00;
      chk("irq", {7'h00, irqOut}, {7'h00, exp_irq(p[7:1], e)});
      acc(0, 8'hC7, 8'h00); chk("st", r, exp_st(p[7:1], e));
      chk("irq clr", {7'h00, irqOut}, 8'h00);
      acc(0, 8'hC7, 8'h00); chk("clr", r, 8'h00);
    end
    acc(1, 8'hC6, 8'h03); ev[1] = 1; acc(0, 8'hC7, 8'h00); ev = 7'h00; chk("race", r, 8'h00);
    acc(0, 8'hC7, 8'h00); chk("set wins", r, 8'h03);
    chk("host", {7'h00, irqSeen}, 8'h01);
    end_of_test();
  end
endmodule : tb_lai_irq_unit

// ==== inc/lai_pkg.sv ====
// Purpose: Constants for the link authentication interrupt unit
// Assumes: 8-bit register port on the device's internal register bus
// Notes:   Status and enable share bit positions 7..1; bit 0 is global
package lai_pkg;
  localparam int          REG_AW        = 8;
  localparam int          REG_DW        = 8;
  localparam int          NUM_SRC       = 7;
  // Register offsets
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'hC6;
  localparam logic [7:0]  ADDR_IRQ_ST   = 8'hC7;
  // Reset values
  localparam logic [7:0]  RST_IRQ_EN    = 8'h00;
  localparam logic [7:0]  RST_IRQ_ST    = 8'h00;
  // Bit positions
  localparam int          BIT_GLOBAL    = 0;
  localparam int          BIT_AUTH_OK   = 1;
  localparam int          BIT_AUTH_FAIL = 2;
  localparam int          BIT_KEYVEC    = 3;
  localparam int          BIT_KEYLIST   = 4;
  localparam int          BIT_DOWNSTRM  = 5;
  localparam int          BIT_RXDET     = 6;
  localparam int          BIT_INDIRECT  = 7;
endpackage : lai_pkg
